/* dv/ifd_pipe_model.sv */
// pipeline side of the interrupt dispatch block: fetch status and vector table
// assumes the bench steers halt and first and that every word sits on mclk
`timescale 1ns/1ps
module ifd_pipe_model
	import ifd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        halt,
	input  wire logic        first,
	input  wire logic        vec_rd_q,
	input  wire logic [23:0] vec_addr_q,
	output ifd_fetch_t       fetch,
	output logic      [23:0] vec_data
);
	logic tick_q;

	// vector word stands one cycle only, otherwise inverted so a late sample shows
	always_ff @(posedge mclk)
	begin
		tick_q <= sys_rst ? 1'b0 : ~tick_q;
		if (sys_rst)
			vec_data <= 24'h000000;
		else
			vec_data <= vec_rd_q ? {8'hA5, vec_addr_q[15:0]} : ~vec_data;
	end

	// fixed return addresses keep the pushed value predictable
	assign fetch = '{boundary: ~halt, halted: halt, first_cycle: first, repeat_on: 1'b0,
		dly_branch: 1'b0, instr_done: tick_q, addr: 24'h000100, next_addr: 24'h000104};
endmodule : ifd_pipe_model

/* dv/test_ifd_top.sv */
// self-checking bench of the interrupt flag dispatch block
// assumes the pipeline model answers vector reads and fetch status
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ifd_top;
	import ifd_pkg::*;
	logic        mclk, sys_rst, bus_we, bus_re, st_restore, dma_int_ready, halt, first;
	logic [7:0]  bus_addr;
	logic [31:0] bus_wdata, bus_rdata_q, rv;
	logic [3:0]  external_request_pin_n, dma_src_q;
	logic [6:0]  periph_req;
	logic [15:0] st_restore_data, cpu_status_word_q, seed;
	logic [10:0] cpu_req_q, dma_req_q, fl;
	logic [23:0] vec_data, vec_addr_q, push_addr_q, pc_value_q, dummy_addr_q;
	logic        int_block_q, vec_rd_q, discard_fetch_q, push_q, pc_load_q, handler_exec_q;
	logic        dma_int_q, acknowledge_strobe_q, dummy_rd_q;
	logic [1:0]  dma_sync_sel_q;
	ifd_fetch_t  fetch;
	ifd_ack_t    ack_instr;
	int          errors, checked, n, lo;
	logic [7:0]  radr [5];
	logic        seen;

	ifd_top dut (.mclk, .sys_rst, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata_q,
		.external_request_pin_n, .periph_req, .fetch, .st_restore, .st_restore_data,
		.dma_int_ready, .ack_instr, .vec_data, .cpu_status_word_q, .cpu_req_q, .dma_req_q,
		.int_block_q, .vec_rd_q, .vec_addr_q, .discard_fetch_q, .push_q, .push_addr_q,
		.pc_load_q, .pc_value_q, .handler_exec_q, .dma_int_q, .dma_src_q, .dma_sync_sel_q,
		.acknowledge_strobe_q, .dummy_rd_q, .dummy_addr_q);
	ifd_pipe_model model (.mclk, .sys_rst, .halt, .first, .vec_rd_q, .vec_addr_q, .fetch,
		.vec_data);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic int low_idx(input logic [10:0] v);
		int r;
		r = 0;
		for (int i = 10; i >= 0; i--)
			if (v[i])
				r = i;
		return r;
	endfunction : low_idx

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_we <= 1'b1;
		@(posedge mclk);
		bus_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		bus_addr <= a;
		bus_re <= 1'b1;
		@(posedge mclk);
		bus_re <= 1'b0;
		#1 rv = bus_rdata_q;
	endtask : rd

	task automatic print_verdict();
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// the whole sequence needs well under two thousand cycles
	initial
	begin
		#20000;
		errors++;
		print_verdict();
	end

	initial
	begin
		{bus_we, bus_re, st_restore, dma_int_ready, halt, first} = '0;
		{bus_addr, bus_wdata, periph_req, st_restore_data} = '0;
		external_request_pin_n = 4'hF;
		ack_instr = '0;
		seed = 16'h0028;
		sys_rst = 1'b1;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		radr = '{A_FLAGS, A_ENABLE, A_STATUS, A_DMACTL, 8'h20};
		foreach (radr[i])
		begin
			rd(radr[i]);
			`CHK(rv, 32'h00000000)
		end
		repeat (4)
		begin
			seed = lfsr(seed);
			wr(A_FLAGS, {21'h0, seed[10:0]});
			rd(A_FLAGS);
			`CHK(rv, {21'h0, seed[10:0]})
		end
		wr(A_FLAGS, 32'h0);
		@(posedge mclk);
		external_request_pin_n <= 4'hD;
		@(posedge mclk);
		external_request_pin_n <= 4'hF;
		periph_req <= 7'h10;
		@(posedge mclk);
		periph_req <= 7'h00;
		repeat (6) @(posedge mclk);
		rd(A_FLAGS);
		`CHK(rv, 32'h00000102)
		for (int k = 0; k < 2; k++)
		begin
			wr(A_FLAGS, 32'h0);
			seed = lfsr(seed);
			fl = seed[10:0] | 11'h400;
			lo = low_idx(fl);
			halt <= 1'b1;
			first <= k[0];
			wr(A_ENABLE, 32'h000007FF);
			wr(A_FLAGS, {21'h0, fl});
			wr(A_STATUS, 32'h1 << GIE_BIT);
			repeat (20) @(posedge mclk);
			rd(A_FLAGS);
			`CHK(rv, {21'h0, fl})
			`CHK(cpu_req_q, fl)
			halt <= 1'b0;
			n = 0;
			seen = 1'b0;
			while (vec_rd_q !== 1'b1 && n < 30)
			begin
				@(posedge mclk);
				#1 n++;
				seen = seen | (discard_fetch_q === 1'b1);
			end
			`CHK(seen, k[0])
			`CHK(vec_addr_q, 24'(lo + 1))
			@(posedge mclk);
			#1 `CHK(push_q, 1'b1)
			`CHK(int_block_q, 1'b1)
			`CHK(push_addr_q, (k ? 24'h000100 : 24'h000104))
			@(posedge mclk);
			#1 `CHK(pc_value_q, {8'hA5, 16'(lo + 1)})
			`CHK(cpu_status_word_q[GIE_BIT], 1'b0)
			`CHK(pc_load_q, 1'b1)
			`CHK(int_block_q, 1'b0)
			repeat (3) @(posedge mclk);
			#1 `CHK(handler_exec_q, 1'b1)
			rd(A_FLAGS);
			`CHK(rv, {21'h0, fl & ~(11'h1 << lo)})
		end
		wr(A_FLAGS, 32'h0);
		wr(A_ENABLE, 32'h1 << (DMA_EN_LSB + 5));
		dma_int_ready <= 1'b1;
		wr(A_FLAGS, 32'h20);
		repeat (5) @(posedge mclk);
		rd(A_FLAGS);
		`CHK(rv, 32'h00000020)
		`CHK(dma_req_q, 11'h000)
		wr(A_DMACTL, 32'h1);
		n = 0;
		#1;
		while (dma_int_q !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			#1 n++;
		end
		`CHK(dma_int_q, 1'b1)
		`CHK(dma_src_q, 4'h5)
		`CHK(dma_sync_sel_q, 2'h1)
		rd(A_FLAGS);
		`CHK(rv, 32'h00000000)
		for (int e = 0; e < 2; e++)
		begin
			@(posedge mclk);
			ack_instr <= '{1'b1, e[0], 24'h00ABCD + 24'(e)};
			@(posedge mclk);
			ack_instr.valid <= 1'b0;
			#1 `CHK(acknowledge_strobe_q, e[0])
			`CHK(dummy_rd_q, e[0])
			`CHK(dummy_addr_q, 24'h00ABCD + 24'(e))
		end
		print_verdict();
	end
endmodule : test_ifd_top

/* logic/ifd_pkg.sv */
// constants, types and the priority function of the interrupt flag dispatch block
// assumes one machine clock domain and a synchronous active-high reset
package ifd_pkg;
	localparam int          NSRC        = 11;
	localparam int          NEXT        = 4;
	localparam int          GIE_BIT     = 13;
	localparam int          DMA_EN_LSB  = 16;
	localparam int          LAT_CYC     = 8;
	localparam logic [7:0]  A_FLAGS     = 8'h00;
	localparam logic [7:0]  A_ENABLE    = 8'h04;
	localparam logic [7:0]  A_STATUS    = 8'h08;
	localparam logic [7:0]  A_DMACTL    = 8'h0C;
	localparam logic [7:0]  A_STATE     = 8'h10;
	localparam logic [10:0] FLAGS_RST   = 11'h000;
	localparam logic [31:0] ENABLE_RST  = 32'h0000_0000;
	localparam logic [15:0] STATUS_RST  = 16'h0000;
	localparam logic [1:0]  SYNC_OFF    = 2'h0;
	localparam logic [1:0]  HOLD_BRANCH = 2'h3;
	localparam logic [3:0]  EXT_IDLE    = 4'hF;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_BLOCK = 8'h02,
		ST_VECT  = 8'h04,
		ST_CLR   = 8'h08,
		ST_FILL1 = 8'h10,
		ST_FILL2 = 8'h20,
		ST_FILL3 = 8'h40,
		ST_EXEC  = 8'h80
	} ifd_state_t;

	typedef struct packed {
		logic        boundary;
		logic        halted;
		logic        first_cycle;
		logic        repeat_on;
		logic        dly_branch;
		logic        instr_done;
		logic [23:0] addr;
		logic [23:0] next_addr;
	} ifd_fetch_t;

	typedef struct packed {
		logic        valid;
		logic        ext;
		logic [23:0] addr;
	} ifd_ack_t;

	// {valid, index} of the lowest set bit; bit 0 has the highest priority
	function automatic logic [4:0] ifd_lowest(input logic [10:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (v[i])
				r = {1'b1, 4'(i)};
		end
		return r;
	endfunction : ifd_lowest
endpackage : ifd_pkg

/* logic/ifd_top.sv */
// interrupt flag register, enables, cpu sequencer and dma dispatch
// assumes pins are asynchronous, pipeline and dma signals are on mclk
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ifd_top
	import ifd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_we,
	input  wire logic        bus_re,
	output logic      [31:0] bus_rdata_q,
	input  wire logic [3:0]  external_request_pin_n,
	input  wire logic [6:0]  periph_req,
	input  wire ifd_fetch_t  fetch,
	input  wire logic        st_restore,
	input  wire logic [15:0] st_restore_data,
	input  wire logic        dma_int_ready,
	input  wire ifd_ack_t    ack_instr,
	input  wire logic [23:0] vec_data,
	output logic      [15:0] cpu_status_word_q,
	output logic      [10:0] cpu_req_q,
	output logic      [10:0] dma_req_q,
	output logic             int_block_q,
	output logic             vec_rd_q,
	output logic      [23:0] vec_addr_q,
	output logic             discard_fetch_q,
	output logic             push_q,
	output logic      [23:0] push_addr_q,
	output logic             pc_load_q,
	output logic      [23:0] pc_value_q,
	output logic             handler_exec_q,
	output logic             dma_int_q,
	output logic      [3:0]  dma_src_q,
	output logic      [1:0]  dma_sync_sel_q,
	output logic             acknowledge_strobe_q,
	output logic             dummy_rd_q,
	output logic      [23:0] dummy_addr_q
);
	ifd_state_t  state_q, state_d;
	logic [3:0]  ext_s1_q, ext_s2_q, ext_s3_q;
	logic [10:0] flags_q;
	logic [31:0] source_enable_register_q;
	logic [1:0]  hold_q;
	logic [3:0]  src_q;
	logic [23:0] ret_q;

	// bit map: 3..0 external pins, 10..4 internal, any bit can be a dma source through its enable
	wire [10:0] ext_lvl  = {7'h00, ~ext_s3_q};
	wire [10:0] int_pulse = {periph_req, 4'h0};
	wire        cpu_global_enable      = cpu_status_word_q[GIE_BIT];
	wire [10:0] cpu_en   = source_enable_register_q[10:0];
	wire [10:0] dma_en   = source_enable_register_q[DMA_EN_LSB +: NSRC];
	// dma side enable is hidden from software: sync mode and dma readiness
	wire        dma_ge   = (dma_sync_sel_q != SYNC_OFF) & dma_int_ready;
	wire [10:0] cpu_req  = flags_q & cpu_en & {NSRC{cpu_global_enable}};
	wire [10:0] dma_req  = flags_q & dma_en & {NSRC{dma_ge}};
	wire        fetch_ok = fetch.boundary & ~fetch.halted & ~fetch.repeat_on
		& (hold_q == 2'h0);
	wire [4:0]  cpu_pick = ifd_lowest(cpu_req);
	wire [4:0]  dma_pick = ifd_lowest(dma_req);
	wire        recog    = (state_q == ST_IDLE) & fetch_ok & cpu_pick[4];
	wire        dma_take = fetch_ok & dma_pick[4];
	// one flag bit from a source index; both clear paths share it
	function automatic logic [10:0] ifd_src_bit(input logic [3:0] idx);
		return 11'(11'h001 << idx);
	endfunction : ifd_src_bit

	wire [10:0] cpu_clr  = (state_q == ST_CLR) ? ifd_src_bit(src_q) : 11'h000;
	wire [10:0] dma_clr  = dma_take ? ifd_src_bit(dma_pick[3:0]) : 11'h000;
	wire [10:0] hw_clr   = cpu_clr | dma_clr;

	wire        wr_flags  = bus_we & (bus_addr == A_FLAGS);
	wire        wr_enable = bus_we & (bus_addr == A_ENABLE);
	wire        wr_status = bus_we & (bus_addr == A_STATUS);
	wire        wr_dmactl = bus_we & (bus_addr == A_DMACTL);

	// a pin held low is a level: the acknowledge clear wins for one cycle only,
	// internal pulses would be lost that way, so they win over every clear
	wire [10:0] flags_base = wr_flags ? bus_wdata[10:0] : flags_q;
	wire [10:0] flags_d    = ((flags_base | ext_lvl) & ~hw_clr)
		| int_pulse;

	// pipeline restore lands last and overrides the acknowledge clear
	wire [15:0] st_clr = (state_q == ST_CLR)
		? (cpu_status_word_q & ~(16'h0001 << GIE_BIT)) : cpu_status_word_q;
	wire [15:0] st_d   = st_restore ? st_restore_data
		: (wr_status ? bus_wdata[15:0] : st_clr);

	wire [1:0]  hold_d = fetch.dly_branch ? HOLD_BRANCH
		: ((fetch.instr_done & (hold_q != 2'h0)) ? hold_q - 2'h1 : hold_q);

	wire [31:0] rd_mux =
		(bus_addr == A_FLAGS)  ? {21'h000000, flags_q} :
		(bus_addr == A_ENABLE) ? source_enable_register_q :
		(bus_addr == A_STATUS) ? {16'h0000, cpu_status_word_q} :
		(bus_addr == A_DMACTL) ? {30'h00000000, dma_sync_sel_q} :
		(bus_addr == A_STATE)  ? {18'h00000, src_q, hold_q, state_q} :
		32'h0000_0000;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:  state_d = recog ? ST_BLOCK : ST_IDLE;
			ST_BLOCK: state_d = ST_VECT;
			ST_VECT:  state_d = ST_CLR;
			ST_CLR:   state_d = ST_FILL1;
			ST_FILL1: state_d = ST_FILL2;
			ST_FILL2: state_d = ST_FILL3;
			ST_FILL3: state_d = ST_EXEC;
			ST_EXEC:  state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	// synchroniser is held at idle through reset, so no pin is seen until after release
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ext_s1_q <= EXT_IDLE;
			ext_s2_q <= EXT_IDLE;
			ext_s3_q <= EXT_IDLE;
		end
		else
		begin
			ext_s1_q <= external_request_pin_n;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			flags_q                  <= FLAGS_RST;
			source_enable_register_q <= ENABLE_RST;
			cpu_status_word_q        <= STATUS_RST;
			dma_sync_sel_q           <= SYNC_OFF;
			hold_q                   <= 2'h0;
			bus_rdata_q              <= 32'h0000_0000;
		end
		else
		begin
			flags_q           <= flags_d;
			cpu_status_word_q <= st_d;
			hold_q            <= hold_d;
			bus_rdata_q       <= bus_re ? rd_mux : 32'h0000_0000;
			if (wr_enable)
				source_enable_register_q <= bus_wdata;
			if (wr_dmactl)
				dma_sync_sel_q <= bus_wdata[1:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_q         <= ST_IDLE;
			src_q           <= 4'h0;
			ret_q           <= 24'h000000;
			int_block_q     <= 1'b0;
			vec_rd_q        <= 1'b0;
			vec_addr_q      <= 24'h000000;
			discard_fetch_q <= 1'b0;
			push_q          <= 1'b0;
			push_addr_q     <= 24'h000000;
			pc_load_q       <= 1'b0;
			pc_value_q      <= 24'h000000;
			handler_exec_q  <= 1'b0;
		end
		else
		begin
			state_q         <= state_d;
			int_block_q     <= (state_d == ST_BLOCK) | (state_d == ST_VECT)
				| (state_d == ST_CLR);
			vec_rd_q        <= (state_d == ST_VECT);
			vec_addr_q      <= {20'h00000, src_q} + 24'h000001;
			discard_fetch_q <= recog & fetch.first_cycle;
			push_q          <= (state_d == ST_CLR);
			push_addr_q     <= ret_q;
			pc_load_q       <= (state_q == ST_CLR);
			handler_exec_q  <= (state_d == ST_EXEC);
			if (state_q == ST_CLR)
				pc_value_q <= vec_data;
			if (recog)
			begin
				src_q <= cpu_pick[3:0];
				ret_q <= fetch.first_cycle ? fetch.addr : fetch.next_addr;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cpu_req_q            <= 11'h000;
			dma_req_q            <= 11'h000;
			dma_int_q            <= 1'b0;
			dma_src_q            <= 4'h0;
			acknowledge_strobe_q <= 1'b0;
			dummy_rd_q           <= 1'b0;
			dummy_addr_q         <= 24'h000000;
		end
		else
		begin
			cpu_req_q            <= cpu_req;
			dma_req_q            <= dma_req;
			dma_int_q            <= dma_take;
			dma_src_q            <= dma_take ? dma_pick[3:0] : dma_src_q;
			acknowledge_strobe_q <= ack_instr.valid & ack_instr.ext;
			dummy_rd_q           <= ack_instr.valid & ack_instr.ext;
			dummy_addr_q         <= ack_instr.valid ? ack_instr.addr : dummy_addr_q;
		end
	end

	sequence s_enter;
		state_q == ST_BLOCK ##1 state_q == ST_VECT ##1 state_q == ST_CLR;
	endsequence
	sequence s_block_hold;
		int_block_q [*3] ##1 !int_block_q;
	endsequence
	sequence s_fill;
		state_q == ST_FILL1 ##1 state_q == ST_FILL2 ##1 state_q == ST_FILL3
			##1 state_q == ST_EXEC;
	endsequence

	a_seq_order: assert property (@(posedge mclk) disable iff (sys_rst)
		recog |=> s_enter ##1 s_fill)
		else $error("dispatch sequence out of order");
	a_exec_latency: assert property (@(posedge mclk) disable iff (sys_rst)
		recog |-> ##7 handler_exec_q)
		else $error("handler not entered in cycle eight");
	a_ack_boundary: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(int_block_q) |-> $past(fetch.boundary && !fetch.halted && !fetch.repeat_on))
		else $error("acknowledge off a fetch boundary");
	a_ext_set: assert property (@(posedge mclk) disable iff (sys_rst)
		(!ext_s3_q[0] && !hw_clr[0]) |=> flags_q[0])
		else $error("external request did not set flag");
	a_flag_rearm: assert property (@(posedge mclk) disable iff (sys_rst)
		(cpu_clr[0] && !ext_s3_q[0]) |=> !flags_q[0] ##1 ($past(ext_s3_q[0]) || flags_q[0]))
		else $error("flag not cleared for one cycle then rearmed");
	a_reset_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		$past(sys_rst) |-> flags_q == FLAGS_RST)
		else $error("flags not zero after reset");
	a_sw_write: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_flags && hw_clr == 11'h000) |=> flags_q == $past(bus_wdata[10:0] | ext_lvl | int_pulse))
		else $error("software flag write lost");
	a_int_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		periph_req[0] |=> flags_q[4])
		else $error("internal pulse not latched");
	a_req_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		(cpu_req_q != 11'h000) |-> $past(cpu_global_enable))
		else $error("cpu request without global enable");
	a_dma_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		(dma_sync_sel_q == SYNC_OFF && $past(dma_sync_sel_q) == SYNC_OFF) |-> !dma_int_q)
		else $error("dma dispatched without sync mode");
	a_dma_take: assert property (@(posedge mclk) disable iff (sys_rst)
		dma_take |=> dma_int_q && dma_src_q == $past(dma_pick[3:0]))
		else $error("dma dispatch wrong source");
	a_branch_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(hold_q != 2'h0) |-> !recog && !dma_take)
		else $error("interrupt taken during branch holdoff");
	a_gie_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_q == ST_CLR && !st_restore && !wr_status) |=> !cpu_status_word_q[GIE_BIT])
		else $error("global enable not cleared");
	a_restore_wins: assert property (@(posedge mclk) disable iff (sys_rst)
		st_restore |=> cpu_status_word_q == $past(st_restore_data))
		else $error("status restore lost");
	a_push_addr: assert property (@(posedge mclk) disable iff (sys_rst)
		($rose(int_block_q) && $past(fetch.first_cycle)) |-> ##2 push_q
			&& push_addr_q == $past(fetch.addr, 3))
		else $error("wrong return address pushed");
	a_pc_load: assert property (@(posedge mclk) disable iff (sys_rst)
		pc_load_q |-> pc_value_q == $past(vec_data))
		else $error("vector not loaded into pc");
	a_ack_strobe: assert property (@(posedge mclk) disable iff (sys_rst)
		(ack_instr.valid && ack_instr.ext) |=> acknowledge_strobe_q && dummy_rd_q
			&& dummy_addr_q == $past(ack_instr.addr))
		else $error("acknowledge strobe missing");

	a_strobe_cause: assert property (@(posedge mclk) disable iff (sys_rst)
		acknowledge_strobe_q |-> $past(ack_instr.valid) && $past(ack_instr.ext))
		else $error("acknowledge strobe without instruction");

	a_block_len: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(int_block_q) |-> s_block_hold)
		else $error("interrupt block not three cycles");

	a_vec_window: assert property (@(posedge mclk) disable iff (sys_rst)
		vec_rd_q |-> int_block_q && $past(int_block_q))
		else $error("vector read outside block window");

	a_handler_end: assert property (@(posedge mclk) disable iff (sys_rst)
		handler_exec_q |=> !handler_exec_q && state_q == ST_IDLE)
		else $error("handler entry not a single pulse");

	a_cpu_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_q == ST_CLR && !int_pulse[src_q]) |=> !flags_q[$past(src_q)])
		else $error("acknowledged flag not cleared");

	a_dma_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(dma_take && !int_pulse[dma_pick[3:0]]) |=> !flags_q[$past(dma_pick[3:0])])
		else $error("dma response left its flag set");

	a_discard_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		discard_fetch_q |-> $rose(int_block_q))
		else $error("fetch discarded outside recognition");

	a_sync_chain: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst) |-> ext_s3_q == $past(ext_s2_q) && ext_s2_q == $past(ext_s1_q))
		else $error("pin synchroniser skipped a stage");

	a_hold_load: assert property (@(posedge mclk) disable iff (sys_rst)
		fetch.dly_branch |=> hold_q == HOLD_BRANCH)
		else $error("branch holdoff not loaded");

	a_hold_count: assert property (@(posedge mclk) disable iff (sys_rst)
		(fetch.instr_done && !fetch.dly_branch && hold_q != 2'h0)
			|=> hold_q == $past(hold_q) - 2'h1)
		else $error("branch holdoff not counted down");

	a_status_wr: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_status && !st_restore) |=> cpu_status_word_q == $past(bus_wdata[15:0]))
		else $error("status write lost");

	a_enable_wr: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_enable |=> source_enable_register_q == $past(bus_wdata))
		else $error("enable write lost");

	a_dma_enable: assert property (@(posedge mclk) disable iff (sys_rst)
		dma_int_q |-> $past(dma_ge))
		else $error("dma dispatched without its enable");

	a_rdata_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!bus_re |=> bus_rdata_q == 32'h0000_0000)
		else $error("read data outside read cycle");
endmodule : ifd_top
